// [dgpio_top.sv]
// Purpose: Dual GPIO port with change and edge interrupts, Avalon-MM slave.
// Assumes: 100 MHz i_clk; byte addresses; one word per register.
// Notes:   Answers each request with waitrequest low on the second cycle.
module dgpio_top (
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Avalon-MM slave.
    input  wire logic [9:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // First port pins.
    input  wire logic [5:0]  i_pa_in,
    output logic      [5:0]  o_pa_out,
    output logic      [5:0]  o_pa_oe_n,
    // Second port pins.
    input  wire logic [7:0]  i_pb_in,
    output logic      [7:0]  o_pb_out,
    output logic      [7:0]  o_pb_oe_n,
    output logic      [7:0]  o_pb_pullup_en,
    // Alternate functions.
    input  wire logic        i_low_voltage_programming,
    output logic             o_timer_ext_clock_in,
    output logic             o_lv_program_enable_pin,
    output logic             o_serial_program_clock_pin,
    output logic             o_serial_program_data_pin,
    output logic      [5:0]  o_analog_select,
    // Interrupt and wake.
    output logic             o_irq,
    output logic             o_wake
);
    // Pin synchronisers.
    dgpio_pin_if #(.W(dgpio_pkg::PA_W)) pa_if ();
    dgpio_pin_if #(.W(dgpio_pkg::PB_W)) pb_if ();
    dgpio_pin_if #(.W(1))               lvp_if ();
    assign pa_if.raw  = i_pa_in;
    assign pb_if.raw  = i_pb_in;
    assign lvp_if.raw = i_low_voltage_programming;
    dgpio_pin_sync #(.W(dgpio_pkg::PA_W)) u_pa_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .pins  (pa_if.sync)
    );
    dgpio_pin_sync #(.W(dgpio_pkg::PB_W)) u_pb_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .pins  (pb_if.sync)
    );
    dgpio_pin_sync #(.W(1)) u_lvp_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .pins  (lvp_if.sync)
    );

    // Registers.
    dgpio_pkg::dgpio_bus_state_t state_reg;
    dgpio_pkg::dgpio_bus_state_t state_next;
    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic [5:0]  pa_latch_reg;
    logic [7:0]  pb_latch_reg;
    logic [5:0]  pa_dir_reg;
    logic [7:0]  pb_dir_reg;
    logic [7:0]  option_reg;
    logic [7:0]  analog_reg;
    logic [1:0]  irq_mask_reg;
    logic        pc_flag_reg;
    logic        ext_flag_reg;
    logic        ext_prev_reg;
    logic [5:0]  pa_out_reg;
    logic [5:0]  pa_oe_n_reg;
    logic [7:0]  pb_out_reg;
    logic [7:0]  pb_oe_n_reg;
    logic [7:0]  pullup_reg;
    logic [5:0]  analog_sel_reg;
    logic [3:0]  alt_reg;
    logic        irq_reg;
    logic        wake_reg;

    // Address decode.
    wire logic [7:0] idx      = i_avs_address[9:2];
    wire logic       addr_ok  = (i_avs_address[1:0] == 2'h0);
    wire logic       req      = i_avs_read | i_avs_write;
    wire logic       accept   = req & (state_reg == dgpio_pkg::BUS_ACK);
    wire logic       wr_acc   = accept & i_avs_write;
    wire logic       be0      = i_avs_byteenable[0];
    wire logic [7:0] wbyte    = i_avs_writedata[7:0];
    wire logic       sel_pa   = addr_ok & (idx == dgpio_pkg::IDX_PORT_A);
    wire logic       sel_pb   = addr_ok & (idx == dgpio_pkg::IDX_PORT_B);
    wire logic       sel_ic   = addr_ok & (idx == dgpio_pkg::IDX_INTR);
    wire logic       sel_opt  = addr_ok & (idx == dgpio_pkg::IDX_OPTION);
    wire logic       sel_da   = addr_ok & (idx == dgpio_pkg::IDX_DIR_A);
    wire logic       sel_db   = addr_ok & (idx == dgpio_pkg::IDX_DIR_B);
    wire logic       sel_an   = addr_ok & (idx == dgpio_pkg::IDX_ANALOG);
    wire logic       sel_msk  = addr_ok & (idx == dgpio_pkg::IDX_IRQ_MASK);

    // Analog selection and digital pin view.
    wire logic [3:0] pcfg     = analog_reg[3:0];
    wire logic       all_dig  = (pcfg == dgpio_pkg::PCFG_DIGITAL_A) |
                                (pcfg == dgpio_pkg::PCFG_DIGITAL_B);
    wire logic [5:0] an_mask  = all_dig ? 6'h00 : dgpio_pkg::PA_ANALOG_PINS;
    wire logic [5:0] pa_pins  = pa_if.clean & ~an_mask;
    wire logic [7:0] pb_pins  = pb_if.clean;
    wire logic       lvp_on   = lvp_if.clean[0];

    // Read data selection; unmapped offsets read as zero.
    wire logic [7:0] rd_byte  =
        sel_pa  ? {2'b00, pa_pins} :
        sel_pb  ? pb_pins :
        sel_ic  ? {6'h00, ext_flag_reg, pc_flag_reg} :
        sel_opt ? option_reg :
        sel_da  ? {2'b00, pa_dir_reg} :
        sel_db  ? pb_dir_reg :
        sel_an  ? analog_reg :
        sel_msk ? {6'h00, irq_mask_reg} :
                  8'h00;

    // Bus handshake: data is captured on the first cycle, the request is
    // completed on the second, so side effects happen once per access.
    assign state_next = (state_reg == dgpio_pkg::BUS_IDLE) ?
                        (req ? dgpio_pkg::BUS_ACK : dgpio_pkg::BUS_IDLE) :
                        dgpio_pkg::BUS_IDLE;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= dgpio_pkg::BUS_IDLE;
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0;
        end else begin
            state_reg <= state_next;
            wait_reg  <= (state_next != dgpio_pkg::BUS_ACK);
            if ((state_reg == dgpio_pkg::BUS_IDLE) && req) begin
                rdata_reg <= {24'h0, rd_byte};
            end
        end
    end

    // Port latch writes merge sampled pin levels into unwritten lanes.
    wire logic [5:0] pa_wval  = be0 ? wbyte[5:0] : pa_pins;
    wire logic [7:0] pb_wval  = be0 ? wbyte : pb_pins;
    wire logic       cfg_wr   = wr_acc & be0;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pa_latch_reg <= 6'h00;
            pb_latch_reg <= 8'h00;
        end else begin
            if (wr_acc && sel_pa) begin
                pa_latch_reg <= pa_wval;
            end
            if (wr_acc && sel_pb) begin
                pb_latch_reg <= pb_wval;
            end
        end
    end

    // Configuration registers.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pa_dir_reg   <= dgpio_pkg::RST_DIR_A;
            pb_dir_reg   <= dgpio_pkg::RST_DIR_B;
            option_reg   <= dgpio_pkg::RST_OPTION;
            analog_reg   <= dgpio_pkg::RST_ANALOG;
            irq_mask_reg <= dgpio_pkg::RST_IRQ_MASK;
        end else if (cfg_wr) begin
            if (sel_da) pa_dir_reg <= wbyte[5:0];
            if (sel_db) pb_dir_reg <= wbyte;
            if (sel_opt) option_reg <= wbyte;
            if (sel_an) analog_reg <= wbyte & dgpio_pkg::ANALOG_IMPL_MASK;
            if (sel_msk) irq_mask_reg <= wbyte[1:0];
        end
    end

    // Change detection on the upper nibble of the second port.
    logic [3:0] mismatch;
    wire logic  pb_refresh = accept & sel_pb;
    wire logic [3:0] refresh_val = i_avs_read ? rdata_reg[7:4] : pb_pins[7:4];
    dgpio_change_det u_change (
        .i_clk         (i_clk),
        .i_rst         (i_rst),
        .i_pins        (pb_pins[7:4]),
        .i_dir         (pb_dir_reg[7:4]),
        .i_refresh     (pb_refresh),
        .i_refresh_val (refresh_val),
        .o_mismatch    (mismatch)
    );

    // Flag set and clear terms. A read clears only the bits it reported,
    // so an event landing between capture and completion is kept.
    wire logic ic_rd    = accept & i_avs_read & sel_ic;
    wire logic pc_set   = |mismatch;
    wire logic ext_pin  = pb_pins[dgpio_pkg::PB_EXT_IRQ_BIT];
    wire logic ext_rise = ext_pin & ~ext_prev_reg;
    wire logic ext_fall = ~ext_pin & ext_prev_reg;
    wire logic ext_set  = option_reg[dgpio_pkg::OPT_EDGE_BIT] ?
                          ext_rise : ext_fall;
    wire logic pc_clr   = ic_rd & rdata_reg[dgpio_pkg::IC_PORT_CHANGE_BIT];
    wire logic ext_clr  = ic_rd & rdata_reg[dgpio_pkg::IC_EXT_IRQ_BIT];
    wire logic [1:0] flags = {ext_flag_reg, pc_flag_reg};
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pc_flag_reg  <= 1'b0;
            ext_flag_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            pc_flag_reg  <= pc_set | (pc_flag_reg & ~pc_clr);
            ext_flag_reg <= ext_set | (ext_flag_reg & ~ext_clr);
            ext_prev_reg <= ext_pin;
        end
    end

    // Pin drive terms. The timer pin can only pull low.
    wire logic [5:0] pa_drive  = ~pa_dir_reg;
    wire logic [5:0] pa_od_hi  = dgpio_pkg::PA_OD_MASK & pa_latch_reg;
    wire logic [5:0] pa_oe_nx  = ~pa_drive | pa_od_hi;
    wire logic [5:0] pa_out_nx = pa_latch_reg & ~dgpio_pkg::PA_OD_MASK;
    wire logic [7:0] lvp_mask  = lvp_on ? dgpio_pkg::LVP_PIN_MASK : 8'h00;
    wire logic [7:0] pb_oe_nx  = pb_dir_reg | lvp_mask;
    wire logic       pu_glob   = ~option_reg[dgpio_pkg::OPT_PULLUP_DIS_BIT];
    wire logic [7:0] pu_nx     = {8{pu_glob}} & pb_dir_reg;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pa_out_reg  <= 6'h00;
            pa_oe_n_reg <= 6'h3f;
            pb_out_reg  <= 8'h00;
            pb_oe_n_reg <= 8'hff;
            pullup_reg  <= 8'h00;
        end else begin
            pa_out_reg  <= pa_out_nx;
            pa_oe_n_reg <= pa_oe_nx;
            pb_out_reg  <= pb_latch_reg;
            pb_oe_n_reg <= pb_oe_nx;
            pullup_reg  <= pu_nx;
        end
    end

    // Alternate functions, analog select, interrupt and wake.
    wire logic [3:0] alt_nx = {pa_if.clean[dgpio_pkg::PA_TIMER_BIT],
                               lvp_on & pb_pins[dgpio_pkg::PB_LVP_EN_BIT],
                               lvp_on & pb_pins[dgpio_pkg::PB_PGM_CLK_BIT],
                               lvp_on & pb_pins[dgpio_pkg::PB_PGM_DAT_BIT]};
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            alt_reg        <= 4'h0;
            analog_sel_reg <= 6'h00;
            irq_reg        <= 1'b0;
            wake_reg       <= 1'b0;
        end else begin
            alt_reg        <= alt_nx;
            analog_sel_reg <= an_mask;
            irq_reg        <= |(flags & irq_mask_reg);
            wake_reg       <= pc_flag_reg & irq_mask_reg[0];
        end
    end

    // Output ports.
    assign o_avs_readdata             = rdata_reg;
    assign o_avs_waitrequest          = wait_reg;
    assign o_pa_out                   = pa_out_reg;
    assign o_pa_oe_n                  = pa_oe_n_reg;
    assign o_pb_out                   = pb_out_reg;
    assign o_pb_oe_n                  = pb_oe_n_reg;
    assign o_pb_pullup_en             = pullup_reg;
    assign o_timer_ext_clock_in       = alt_reg[3];
    assign o_lv_program_enable_pin    = alt_reg[2];
    assign o_serial_program_clock_pin = alt_reg[1];
    assign o_serial_program_data_pin  = alt_reg[0];
    assign o_analog_select            = analog_sel_reg;
    assign o_irq                      = irq_reg;
    assign o_wake                     = wake_reg;

    // Checks on the block's outputs and internal state.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    chk_dir_input_hiz: assert property (
        (pb_dir_reg == 8'hff) |=> (o_pb_oe_n == 8'hff))
        else $error("Input pin of second port is driven.");
    chk_dir_output_drv: assert property (
        (pb_dir_reg == 8'h00 && !lvp_on) |=> (o_pb_oe_n == 8'h00))
        else $error("Output pin of second port is not driven.");
    chk_pa_upper_zero: assert property (
        ((state_reg == dgpio_pkg::BUS_IDLE) && req && (sel_pa || sel_da))
        |=> (o_avs_readdata[7:6] == 2'b00 && !o_avs_waitrequest))
        else $error("First port upper bits do not read zero.");
    chk_open_drain: assert property (
        (o_pa_out[4] == 1'b0) &&
        (o_pa_oe_n[4] || ($past(pa_latch_reg[4]) == 1'b0)))
        else $error("Timer pin drives high.");
    chk_analog_reads_zero: assert property (
        ((state_reg == dgpio_pkg::BUS_IDLE) && req && sel_pa && !all_dig)
        |=> ((o_avs_readdata[5:0] & dgpio_pkg::PA_ANALOG_PINS) == 6'h00))
        else $error("Analog pin reads nonzero.");
    chk_pullup_global: assert property (
        option_reg[7] |=> (o_pb_pullup_en == 8'h00))
        else $error("Pull-up on while globally disabled.");
    chk_pullup_output_off: assert property (
        (o_pb_pullup_en & ~$past(pb_dir_reg)) == 8'h00)
        else $error("Pull-up on for an output pin.");
    chk_change_sets_flag: assert property (
        (|mismatch) |=> pc_flag_reg ##1
        (o_wake == $past(irq_mask_reg[0])))
        else $error("Mismatch did not set the change flag or wake.");
    chk_output_excluded: assert property (
        (pb_dir_reg[7:4] == 4'h0) |-> (mismatch == 4'h0))
        else $error("Output pin joined change detection.");
    chk_flag_set_wins: assert property (
        (pc_set && pc_clr) |=> pc_flag_reg)
        else $error("Clear beat a pending mismatch.");
    chk_ext_edge: assert property (
        (option_reg[6] && ext_rise) |=> ext_flag_reg)
        else $error("Rising edge missed on external interrupt.");
    chk_bus_answer: assert property (
        ((state_reg == dgpio_pkg::BUS_IDLE) && req) |=> !o_avs_waitrequest
        ##1 o_avs_waitrequest)
        else $error("Bus answer not one cycle after request.");
    // Falling edges count only while the edge select bit is clear.
    chk_ext_fall_edge: assert property (
        (!option_reg[6] && ext_fall) |=> ext_flag_reg)
        else $error("Falling edge missed on external interrupt.");
    // Programming mode must release the shared second port pins.
    chk_lvp_input: assert property (
        lvp_on |=> ((o_pb_oe_n & dgpio_pkg::LVP_PIN_MASK) ==
        dgpio_pkg::LVP_PIN_MASK))
        else $error("Programming pin driven in programming mode.");
    // First port inputs must leave every pad undriven.
    chk_pa_dir_input: assert property (
        (pa_dir_reg == 6'h3f) |=> (o_pa_oe_n == 6'h3f))
        else $error("Input pin of first port is driven.");
    // Any analog setting marks the shared pins as analog.
    chk_analog_default: assert property (
        !all_dig |=> (o_analog_select == dgpio_pkg::PA_ANALOG_PINS))
        else $error("Analog pins not marked analog.");
    // A port write without its data lane stores the sampled pins.
    chk_port_rmw: assert property (
        (wr_acc && sel_pa && !be0) |=> (pa_latch_reg == $past(pa_pins)))
        else $error("Port write did not merge sampled pins.");
    // Wake stays quiet while the change interrupt is masked.
    chk_wake_masked: assert property (
        !irq_mask_reg[0] |=> !o_wake)
        else $error("Wake raised while masked.");

    cov_pb_write: cover property (wr_acc && sel_pb);
    cov_change_irq: cover property (pc_set ##[1:4] o_irq);
    cov_ext_fall: cover property (!option_reg[6] && ext_fall ##1 ext_flag_reg);
    cov_flag_read_clear: cover property (pc_clr && !pc_set ##1 !pc_flag_reg);
    cov_lvp_mode: cover property (lvp_on ##[1:8] o_lv_program_enable_pin);
endmodule : dgpio_top

// [dgpio_pkg.sv]
// Purpose: Shared constants and types for the dual GPIO port block.
// Assumes: One core clock; registers reached over Avalon-MM.
// Notes:   Register offsets are indices; the byte address is four times.
package dgpio_pkg;
    localparam int PA_W = 6;
    localparam int PB_W = 8;
    localparam int SYNC_STAGES = 3;
    // Register indices.
    localparam logic [7:0] IDX_PORT_A   = 8'h05;
    localparam logic [7:0] IDX_PORT_B   = 8'h06;
    localparam logic [7:0] IDX_INTR     = 8'h0b;
    localparam logic [7:0] IDX_OPTION   = 8'h81;
    localparam logic [7:0] IDX_DIR_A    = 8'h85;
    localparam logic [7:0] IDX_DIR_B    = 8'h86;
    localparam logic [7:0] IDX_ANALOG   = 8'h9f;
    localparam logic [7:0] IDX_IRQ_MASK = 8'ha0;
    // Values after reset.
    localparam logic [5:0] RST_DIR_A    = 6'h3f;
    localparam logic [7:0] RST_DIR_B    = 8'hff;
    localparam logic [7:0] RST_OPTION   = 8'hff;
    localparam logic [7:0] RST_ANALOG   = 8'h00;
    localparam logic [1:0] RST_IRQ_MASK = 2'h0;
    // Field positions and masks.
    localparam logic [7:0] ANALOG_IMPL_MASK = 8'h8f;
    localparam logic [5:0] PA_ANALOG_PINS   = 6'h2f;
    localparam logic [5:0] PA_OD_MASK       = 6'h10;
    localparam logic [3:0] PCFG_DIGITAL_A   = 4'h6;
    localparam logic [3:0] PCFG_DIGITAL_B   = 4'h7;
    localparam logic [7:0] LVP_PIN_MASK     = 8'hc8;
    localparam int OPT_PULLUP_DIS_BIT = 7;
    localparam int OPT_EDGE_BIT       = 6;
    localparam int PA_TIMER_BIT       = 4;
    localparam int PB_EXT_IRQ_BIT     = 0;
    localparam int PB_LVP_EN_BIT      = 3;
    localparam int PB_PGM_CLK_BIT     = 6;
    localparam int PB_PGM_DAT_BIT     = 7;
    localparam int IC_PORT_CHANGE_BIT = 0;
    localparam int IC_EXT_IRQ_BIT     = 1;
    // Bus handshake states.
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } dgpio_bus_state_t;
endpackage : dgpio_pkg

// [dgpio_pin_if.sv]
// Purpose: Carries raw pin levels to the synchroniser and clean levels back.
// Assumes: The user side drives raw from pads.
// Notes:   Clean levels come from flip-flops in the synchroniser.
interface dgpio_pin_if #(parameter int W = 8);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface : dgpio_pin_if

// [dgpio_pin_sync.sv]
// Purpose: Three-stage pin synchroniser with a two-stage agreement filter.
// Assumes: Raw levels are asynchronous to i_clk.
// Notes:   The first stage is read only by the second stage.
module dgpio_pin_sync #(parameter int W = 8) (
    // Clock and reset.
    input  wire logic  i_clk,
    input  wire logic  i_rst,
    // Pin bundle.
    dgpio_pin_if.sync  pins
);
    genvar g;
    // Each bit settles once stages two and three agree, so a metastable
    // second stage cannot glitch the clean level.
    for (g = 0; g < W; g++) begin : g_bit
        logic [2:0] stage_reg;
        logic       clean_reg;
        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                stage_reg <= 3'h0;
                clean_reg <= 1'b0;
            end else begin
                stage_reg <= {stage_reg[1:0], pins.raw[g]};
                if (stage_reg[1] == stage_reg[2]) begin
                    clean_reg <= stage_reg[2];
                end
            end
        end
        assign pins.clean[g] = clean_reg;
    end
endmodule : dgpio_pin_sync

// [dgpio_change_det.sv]
// Purpose: Compares upper second-port inputs with the last latched value.
// Assumes: Refresh pulses come from accepted port reads or writes.
// Notes:   Output pins are masked out of the comparison.
module dgpio_change_det (
    // Clock and reset.
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Pin state and direction.
    input  wire logic [3:0] i_pins,
    input  wire logic [3:0] i_dir,
    // Refresh of the compare latch.
    input  wire logic       i_refresh,
    input  wire logic [3:0] i_refresh_val,
    // Per-pin mismatch.
    output logic      [3:0] o_mismatch
);
    logic [3:0] old_reg;

    // The compare latch takes the value software saw on a read, or the sampled pins on a write.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            old_reg <= 4'h0;
        end else if (i_refresh) begin
            old_reg <= i_refresh_val;
        end
    end

    // Only input pins take part in the comparison.
    assign o_mismatch = (i_pins ^ old_reg) & i_dir;
endmodule : dgpio_change_det

// [dgpio_pad_model.sv]
// Purpose: Pad model for both ports: drivers, pull-ups, far-side levels.
// Assumes: The bench supplies external levels and per-bit drive enables.
// Notes:   Floating pins with no pull-up toggle, so no stale level survives.
module dgpio_pad_model (
    // Clock.
    input  wire logic       i_clk,
    // Device side.
    input  wire logic [5:0] i_pa_out,
    input  wire logic [5:0] i_pa_oe_n,
    input  wire logic [7:0] i_pb_out,
    input  wire logic [7:0] i_pb_oe_n,
    input  wire logic [7:0] i_pb_pull,
    // Far side.
    input  wire logic [5:0] i_pa_ext,
    input  wire logic [7:0] i_pb_ext,
    input  wire logic [7:0] i_pb_ext_en,
    output logic      [5:0] o_pa_pin,
    output logic      [7:0] o_pb_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tgl = 1'b0;
    // A floating line flips every cycle.
    always @(posedge i_clk) tgl <= ~tgl;
    // Driven pins show the latch; bit 4 can only sink.
    assign o_pa_pin = (~i_pa_oe_n & i_pa_out) | (i_pa_oe_n & i_pa_ext);
    // Released pins follow the far side, else the pull-up, else the toggle.
    assign o_pb_pin = (~i_pb_oe_n & i_pb_out) | (i_pb_oe_n &
        ((i_pb_ext_en & i_pb_ext) | (~i_pb_ext_en & (i_pb_pull | {8{tgl}}))));
endmodule : dgpio_pad_model

// [dgpio_top_tb.sv]
// Purpose: Register-level tests of the dual port block.
// Assumes: Pin filter settles within eight cycles.
// Notes:   Byte enable is one except for one read-modify-write port write.
module dgpio_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk, i_rst, rd_o, wr_o, low_voltage_programming, waitr, irq, wake, tclk;
    logic [3:0]  be;
    logic [9:0]  adr;
    logic [31:0] wdat, rdat;
    logic [5:0]  pa_out, pa_oe_n, pa_pin, pa_ext, asel;
    logic [7:0]  pb_out, pb_oe_n, pb_pull, pb_pin, pb_ext, pb_en, x;
    logic [2:0]  prog;
    int          err_total = 0;
    int          n_tests = 0;
    localparam logic [7:0] RI [6] = '{8'h81, 8'h85, 8'h86, 8'h9f, 8'ha0, 8'h40};
    localparam logic [7:0] RE [6] = '{8'hff, 8'h3f, 8'hff, 8'h00, 8'h00, 8'h00};
    dgpio_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr),
        .i_avs_read(rd_o), .i_avs_write(wr_o), .i_avs_writedata(wdat),
        .i_avs_byteenable(be), .o_avs_readdata(rdat),
        .o_avs_waitrequest(waitr), .i_pa_in(pa_pin), .o_pa_out(pa_out),
        .o_pa_oe_n(pa_oe_n), .i_pb_in(pb_pin), .o_pb_out(pb_out),
        .o_pb_oe_n(pb_oe_n), .o_pb_pullup_en(pb_pull),
        .i_low_voltage_programming(low_voltage_programming), .o_timer_ext_clock_in(tclk),
        .o_lv_program_enable_pin(prog[0]), .o_serial_program_clock_pin(prog[1]),
        .o_serial_program_data_pin(prog[2]), .o_analog_select(asel),
        .o_irq(irq), .o_wake(wake));
    dgpio_pad_model pad_u (.i_clk(i_clk), .i_pa_out(pa_out),
        .i_pa_oe_n(pa_oe_n), .i_pb_out(pb_out), .i_pb_oe_n(pb_oe_n),
        .i_pb_pull(pb_pull), .i_pa_ext(pa_ext), .i_pb_ext(pb_ext),
        .i_pb_ext_en(pb_en), .o_pa_pin(pa_pin), .o_pb_pin(pb_pin));
    // Free-running 100 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One bus cycle; the request is held until waitrequest is seen low.
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge i_clk);
        adr  <= {idx, 2'h0};
        wdat <= {24'h0, d};
        wr_o <= w;
        rd_o <= ~w;
        do begin
            @(posedge i_clk);
            n++;
        end while (waitr !== 1'b0 && n < 40);
        if (n >= 40)
            err_total++;
        q = rdat[7:0];
        rd_o <= 1'b0;
        wr_o <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, x);
    endtask : wr
    task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00, x);
        chk(x, e);
    endtask : rdc
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    // Main sequence; software keeps analog pins as inputs until digital.
    initial begin
        {i_rst, rd_o, wr_o, adr, wdat, low_voltage_programming, pa_ext, pb_ext} = '0;
        i_rst = 1'b1;
        pb_en = 8'hff;
        be = 4'h1;
        tick(5);
        i_rst <= 1'b0;
        for (int i = 0; i < 6; i++) rdc(RI[i], RE[i]);
        chk(pb_pull, 8'h00);
        pa_ext <= 6'h3f;
        tick(8);
        rdc(8'h05, 8'h10);
        chk({2'h0, asel}, 8'h2f);
        chk({7'h0, tclk}, 8'h01);
        wr(8'h9f, 8'h06);
        rdc(8'h05, 8'h3f);
        chk({2'h0, asel}, 8'h00);
        wr(8'h85, 8'hff);
        rdc(8'h85, 8'h3f);
        wr(8'h85, 8'h00);
        wr(8'h05, 8'h2a);
        tick(2);
        chk({2'h0, pa_out}, 8'h2a);
        chk({2'h0, pa_oe_n}, 8'h00);
        tick(6);
        rdc(8'h05, 8'h2a);
        wr(8'h05, 8'h10);
        tick(2);
        chk({2'h0, pa_oe_n}, 8'h10);
        // Pull the released timer pin low, then write with no data lane.
        be <= 4'h0;
        pa_ext <= 6'h2f;
        tick(8);
        chk({7'h0, tclk}, 8'h00);
        wr(8'h05, 8'h10);
        be <= 4'h1;
        tick(2);
        chk({2'h0, pa_oe_n}, 8'h00);
        wr(8'h86, 8'hf0);
        wr(8'h81, 8'h7f);
        pb_en <= 8'h00;
        tick(8);
        chk(pb_pull, 8'hf0);
        wr(8'h06, 8'h05);
        tick(2);
        chk(pb_out, 8'h05);
        chk(pb_oe_n, 8'hf0);
        tick(6);
        rdc(8'h06, 8'hf5);
        wr(8'ha0, 8'h03);
        bus(1'b0, 8'h0b, 8'h00, x);
        pb_en <= 8'hf0;
        pb_ext <= 8'hd0;
        tick(8);
        chk({7'h0, irq}, 8'h01);
        chk({7'h0, wake}, 8'h01);
        rdc(8'h0b, 8'h01);
        rdc(8'h0b, 8'h01);
        rdc(8'h06, 8'hd5);
        bus(1'b0, 8'h0b, 8'h00, x);
        rdc(8'h0b, 8'h00);
        wr(8'h86, 8'hef);
        tick(8);
        rdc(8'h0b, 8'h00);
        // Each edge choice, with the far side avoiding a port change meanwhile.
        for (int e = 0; e < 2; e++) begin
            wr(8'h81, {1'b0, e[0], 6'h3f});
            pb_en <= 8'hff;
            pb_ext <= {7'h6f, ~e[0]};
            tick(8);
            bus(1'b0, 8'h0b, 8'h00, x);
            pb_ext[0] <= e[0];
            tick(8);
            rdc(8'h0b, 8'h02);
        end
        wr(8'h86, 8'h00);
        low_voltage_programming <= 1'b1;
        pb_ext <= 8'hff;
        // Mode level and then the released pins each pass the pin filter.
        tick(12);
        chk(pb_oe_n & 8'hc8, 8'hc8);
        chk({5'h0, prog}, 8'h07);
        complete_run;
    end
    // Watchdog against a hung bus or sequence.
    initial begin
        #100000;
        err_total++;
        complete_run;
    end
endmodule : dgpio_top_tb
